// File: bench/ifsb_src.sv
// Purpose: stand-in for the peripherals raising request strobes
// Assumes: fire and lvl change just after a rising edge
// Notes:   bit 16*w+b drives the source at bit b of flag word w
`timescale 1ns/100ps
module ifsb_src (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [79:0] fire,
  input  wire logic [79:0] lvl,
  output logic      [79:0] ev_q
);
  logic [79:0] ev_d;

  // a strobe lasts one cycle; a level source keeps requesting
  always_comb begin
    ev_d = fire | lvl;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_q <= 80'h0;
    end else begin
      ev_q <= ev_d;
    end
  end
endmodule // ifsb_src

// File: bench/ifsb_top_chk.sv
// Purpose: bus and request checks on the flag bank ports
// Assumes: one clock domain, ce high whenever the bus is busy
// Notes:   bound into ifsb_top
`timescale 1ns/100ps
`include "ifsb_regs.svh"
module ifsb_top_chk #(
  parameter int AW = 8
) (
  input wire logic          clk,
  input wire logic          rst_b,
  input wire logic          ce,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic [1:0]    s_axi_rresp,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic [15:0]   req_one,
  input wire logic [15:0]   req_two,
  input wire logic [15:0]   req_three,
  input wire logic [15:0]   req_four,
  input wire logic [15:0]   req_five,
  input wire logic          irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before rready");
  a_r_answer: assert property (
    ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not one cycle after address");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_unmapped_rd: assert property (
    ce && s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h34
    |=> s_axi_rresp == `IFSB_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_req_unimpl: assert property (
    (req_one & ~`IFSB_IMPL_ONE) == 16'h0
    && (req_two & ~`IFSB_IMPL_TWO) == 16'h0
    && (req_three & ~`IFSB_IMPL_THREE) == 16'h0
    && (req_four & ~`IFSB_IMPL_FOUR) == 16'h0
    && (req_five & ~`IFSB_IMPL_FIVE) == 16'h0)
    else $error("request on an unimplemented bit");
  a_irq_or: assert property (
    irq == |{req_one, req_two, req_three, req_four, req_five})
    else $error("irq differs from the or of requests");
  a_irq_sticky: assert property (
    $fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("irq fell without a register write");
  a_b_after: assert property (
    $rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
    else $error("write response before both beats taken");
endmodule // ifsb_top_chk

bind ifsb_top ifsb_top_chk #(.AW(AW)) u_chk (
  .clk(clk), .rst_b(rst_b), .ce(ce),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .req_one(req_one), .req_two(req_two), .req_three(req_three),
  .req_four(req_four), .req_five(req_five), .irq(irq));

// File: bench/ifsb_top_tb.sv
// Purpose: self-checking bench for the flag status bank
// Assumes: ce held high, bus driven on the rising edge
// Notes:   table of register cases, then hand-written cases
`timescale 1ns/100ps
module ifsb_top_tb;
  typedef struct packed {
    logic [7:0]  a;
    logic [15:0] d;
    logic [3:0]  s;
    logic [15:0] x;
    logic [1:0]  r;
  } ifsb_row_t;

  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  aw_a = 8'h0;
  logic [7:0]  ar_a = 8'h0;
  logic [31:0] w_d = 32'h0;
  logic [3:0]  w_s = 4'h0;
  logic        aw_v = 1'b0;
  logic        w_v = 1'b0;
  logic        b_r = 1'b0;
  logic        ar_v = 1'b0;
  logic        r_r = 1'b0;
  logic [79:0] fire = 80'h0;
  logic [79:0] lvl = 80'h0;
  logic [79:0] ev;
  logic        aw_r, w_r, b_v, ar_r, r_v, irq;
  logic [1:0]  b_s, r_s, r;
  logic [31:0] r_d;
  logic [15:0] req1, req2, req3, req4, req5;
  int          n_checks = 0;
  int          n_mismatch = 0;
  int          cyc = 0;
  int          i;
  logic [15:0] im [5] = '{16'hfe1f, 16'h22e3, 16'h4006, 16'h210e, 16'h0040};
  ifsb_row_t   rows [16] = '{
    '{8'h00, 16'hffff, 4'h3, 16'hfe1f, 2'h0},
    '{8'h00, 16'h0, 4'h3, 16'h0, 2'h0},
    '{8'h04, 16'hffff, 4'h3, 16'h22e3, 2'h0},
    '{8'h04, 16'h0, 4'h3, 16'h0, 2'h0},
    '{8'h08, 16'hffff, 4'h3, 16'h4006, 2'h0},
    '{8'h08, 16'h0, 4'h3, 16'h0, 2'h0},
    '{8'h0c, 16'hffff, 4'h3, 16'h210e, 2'h0},
    '{8'h0c, 16'h0, 4'h3, 16'h0, 2'h0},
    '{8'h10, 16'hffff, 4'h3, 16'h0040, 2'h0},
    '{8'h10, 16'h0, 4'h3, 16'h0, 2'h0},
    '{8'h00, 16'hffff, 4'h2, 16'hfe00, 2'h0},
    '{8'h00, 16'h0, 4'h3, 16'h0, 2'h0},
    '{8'h2c, 16'hffff, 4'h3, 16'h210e, 2'h0},
    '{8'h2c, 16'h0, 4'h3, 16'h0, 2'h0},
    '{8'h14, 16'hffff, 4'h3, 16'h0, 2'h2},
    '{8'h40, 16'hffff, 4'h3, 16'h0, 2'h2}};

  always #4 clk = ~clk;

  ifsb_src u_src (.clk(clk), .rst_b(rst_b), .fire(fire), .lvl(lvl), .ev_q(ev));

  ifsb_top #(.AW(8)) dut (
    .clk(clk), .rst_b(rst_b), .ce(ce),
    .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(w_d), .s_axi_wstrb(w_s), .s_axi_wvalid(w_v),
    .s_axi_wready(w_r), .s_axi_bresp(b_s), .s_axi_bvalid(b_v),
    .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_s),
    .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .uart2_tx_evt(ev[15]), .uart2_rx_evt(ev[14]), .ext_irq2_evt(ev[13]),
    .timer5_evt(ev[12]), .timer4_evt(ev[11]), .compare4_evt(ev[10]),
    .compare3_evt(ev[9]), .ext_irq1_evt(ev[4]), .change_notify_evt(ev[3]),
    .comparator_evt(ev[2]), .i2c1_master_evt(ev[1]), .i2c1_slave_evt(ev[0]),
    .parallel_port_evt(ev[29]), .compare5_evt(ev[25]),
    .capture5_evt(ev[23]), .capture4_evt(ev[22]), .capture3_evt(ev[21]),
    .spi2_event_evt(ev[17]), .spi2_fault_evt(ev[16]),
    .calendar_evt(ev[46]), .i2c2_master_evt(ev[34]),
    .i2c2_slave_evt(ev[33]), .charge_measure_evt(ev[61]),
    .low_voltage_evt(ev[56]), .crc_gen_evt(ev[51]),
    .uart2_error_evt(ev[50]), .uart1_error_evt(ev[49]),
    .usb_otg_evt(ev[70]), .req_one(req1), .req_two(req2),
    .req_three(req3), .req_four(req4), .req_five(req5), .irq(irq));

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [15:0] dd,
                     input logic [3:0] s, output logic [1:0] rs);
    @(posedge clk);
    aw_a <= a;
    w_d <= {16'h0, dd};
    w_s <= s;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    forever begin
      @(posedge clk);
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
      if (b_v) begin
        rs = b_s;
        b_r <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rdx(input logic [7:0] a, input logic [15:0] x);
    @(posedge clk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    forever begin
      @(posedge clk);
      if (ar_r) ar_v <= 1'b0;
      if (r_v) begin
        chk("rdata", r_d, {16'h0, x});
        chk("rresp", {30'h0, r_s}, 32'h0);
        r_r <= 1'b0;
        break;
      end
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // 20000 cycles, long enough for a few thousand bus transfers
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    for (i = 0; i < 5; i++) rdx(8'(4 * i), 16'h0);
    for (i = 0; i < 16; i++) begin
      axw(rows[i].a, rows[i].d, rows[i].s, r);
      chk("bresp", {30'h0, r}, {30'h0, rows[i].r});
      @(posedge clk);
      ar_a <= rows[i].a;
      ar_v <= 1'b1;
      r_r <= 1'b1;
      forever begin
        @(posedge clk);
        if (ar_r) ar_v <= 1'b0;
        if (r_v) break;
      end
      r_r <= 1'b0;
      chk("rdata", r_d, {16'h0, rows[i].x});
      chk("rresp", {30'h0, r_s}, {30'h0, rows[i].r});
    end
    $display("register table done");
    for (i = 0; i < 80; i++) begin
      if (im[i / 16][i % 16]) begin
        fire <= 80'h1 << i;
        @(posedge clk);
        fire <= 80'h0;
        rdx(8'(4 * (i / 16)), 16'h1 << (i % 16));
        axw(8'(4 * (i / 16)), 16'h0, 4'h3, r);
        rdx(8'(4 * (i / 16)), 16'h0);
      end
    end
    $display("source layout done");
    axw(8'h20, 16'h8000, 4'h3, r);
    fire <= 80'hc000;
    @(posedge clk);
    fire <= 80'h0;
    repeat (4) @(posedge clk);
    chk("req_one", {16'h0, req1}, 32'h8000);
    chk("irq", {31'h0, irq}, 32'h1);
    axw(8'h20, 16'h0, 4'h3, r);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    rdx(8'h00, 16'hc000);
    axw(8'h20, 16'h4000, 4'h3, r);
    repeat (2) @(posedge clk);
    chk("req_one", {16'h0, req1}, 32'h4000);
    axw(8'h00, 16'h0, 4'h3, r);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("interrupt done");
    lvl <= 80'h1 << 29;
    axw(8'h04, 16'h0, 4'h3, r);
    rdx(8'h04, 16'h2000);
    lvl <= 80'h0;
    axw(8'h04, 16'h0, 4'h3, r);
    rdx(8'h04, 16'h0);
    $display("set wins done");
    // every word enabled so each request output is seen
    for (i = 0; i < 5; i++) axw(8'h20 + 8'(4 * i), 16'hffff, 4'h3, r);
    fire <= {im[4], im[3], im[2], im[1], im[0]};
    @(posedge clk);
    fire <= 80'h0;
    repeat (3) @(posedge clk);
    chk("req_one", {16'h0, req1}, {16'h0, im[0]});
    chk("req_two", {16'h0, req2}, {16'h0, im[1]});
    chk("req_three", {16'h0, req3}, {16'h0, im[2]});
    chk("req_four", {16'h0, req4}, {16'h0, im[3]});
    chk("req_five", {16'h0, req5}, {16'h0, im[4]});
    chk("irq", {31'h0, irq}, 32'h1);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    chk("req_one", {16'h0, req1}, 32'h0);
    rst_b <= 1'b1;
    for (i = 0; i < 5; i++) begin
      rdx(8'(4 * i), 16'h0);
      rdx(8'h20 + 8'(4 * i), 16'h0);
    end
    $display("mid-run reset done");
    tally_and_finish();
  end
endmodule // ifsb_top_tb

// File: core/ifsb_flag_reg.sv
// Purpose: one 16-bit sticky flag or enable word
// Assumes: set, write strobe and mask are synchronous to clk
// Notes:   used for both flag and enable words; enables tie set to zero
`timescale 1ns/100ps
`include "ifsb_regs.svh"
module ifsb_flag_reg #(
  parameter logic [15:0] IMPL = 16'hffff
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic [15:0] set,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  input  wire logic [15:0] wr_mask,
  output logic      [15:0] val_q
);
  logic [15:0] val_d;

  always_comb begin
    val_d = val_q;
    if (wr_en) begin
      val_d = (val_q & ~wr_mask) | (wr_data & wr_mask);
    end
    // set after the write so an event in the clear cycle survives
    val_d = (val_d | set) & IMPL;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      val_q <= `IFSB_RESET_VAL;
    end else if (ce) begin
      val_q <= val_d;
    end
  end
endmodule // ifsb_flag_reg

// File: core/ifsb_pkg.sv
// Purpose: types shared by the flag status bank
// Assumes: nothing
// Notes:   one-hot state codes
package ifsb_pkg;
  typedef enum logic [1:0] {
    IFSB_WR_IDLE = 2'h1,
    IFSB_WR_RESP = 2'h2
  } ifsb_wr_state_t;

  typedef enum logic [1:0] {
    IFSB_RD_IDLE = 2'h1,
    IFSB_RD_RESP = 2'h2
  } ifsb_rd_state_t;
endpackage

// File: core/ifsb_regs.svh
// Purpose: offsets, field positions, masks and reset values of the bank
// Assumes: 32-bit register bus, one aligned word per register
// Notes:   flag and enable words use bits 15:0, upper bits read zero
`ifndef IFSB_REGS_SVH
`define IFSB_REGS_SVH

`define IFSB_NUM_BANKS     5
`define IFSB_FLAG_BASE     8'h00
`define IFSB_EN_BASE       8'h20
`define IFSB_STRIDE        8'h04
`define IFSB_RESET_VAL     16'h0000

`define IFSB_IMPL_ONE      16'hfe1f
`define IFSB_IMPL_TWO      16'h22e3
`define IFSB_IMPL_THREE    16'h4006
`define IFSB_IMPL_FOUR     16'h210e
`define IFSB_IMPL_FIVE     16'h0040

`define IFSB_B_UART2_TX    15
`define IFSB_B_UART2_RX    14
`define IFSB_B_EXT_IRQ2    13
`define IFSB_B_TIMER5      12
`define IFSB_B_TIMER4      11
`define IFSB_B_COMPARE4    10
`define IFSB_B_COMPARE3    9
`define IFSB_B_EXT_IRQ1    4
`define IFSB_B_CHANGE      3
`define IFSB_B_COMPARATOR  2
`define IFSB_B_I2C1_MASTER 1
`define IFSB_B_I2C1_SLAVE  0
`define IFSB_B_PARALLEL    13
`define IFSB_B_COMPARE5    9
`define IFSB_B_CAPTURE5    7
`define IFSB_B_CAPTURE4    6
`define IFSB_B_CAPTURE3    5
`define IFSB_B_SPI2_EVENT  1
`define IFSB_B_SPI2_FAULT  0
`define IFSB_B_CALENDAR    14
`define IFSB_B_I2C2_MASTER 2
`define IFSB_B_I2C2_SLAVE  1
`define IFSB_B_CHARGE      13
`define IFSB_B_LOW_VOLT    8
`define IFSB_B_CRC_GEN     3
`define IFSB_B_UART2_ERR   2
`define IFSB_B_UART1_ERR   1
`define IFSB_B_USB_OTG     6

`define IFSB_RESP_OKAY     2'h0
`define IFSB_RESP_SLVERR   2'h2

`endif

// File: core/ifsb_req_stage.sv
// Purpose: gates pending flags by their enables into request outputs
// Assumes: flags and enables come from registers
// Notes:   one cycle of latency from flag to request
`timescale 1ns/100ps
module ifsb_req_stage #(
  parameter int W = 80
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         ce,
  input  wire logic [W-1:0] flags,
  input  wire logic [W-1:0] enables,
  output logic      [W-1:0] req_q,
  output logic              irq_q
);
  logic [W-1:0] req_d;
  logic         irq_d;

  always_comb begin
    req_d = flags & enables;
    irq_d = |req_d;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_q <= '0;
      irq_q <= 1'b0;
    end else if (ce) begin
      req_q <= req_d;
      irq_q <= irq_d;
    end
  end
endmodule // ifsb_req_stage

// File: core/ifsb_top.sv
// Purpose: interrupt flag status bank with AXI4-Lite register access
// Assumes: event inputs are one-cycle or level strobes synchronous to clk
// Notes:   five flag words, five enable words, per-word request outputs
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
`include "ifsb_regs.svh"
module ifsb_top #(
  parameter int AW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          ce,
  // register bus
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // peripheral events
  input  wire logic          uart2_tx_evt,
  input  wire logic          uart2_rx_evt,
  input  wire logic          ext_irq2_evt,
  input  wire logic          timer5_evt,
  input  wire logic          timer4_evt,
  input  wire logic          compare4_evt,
  input  wire logic          compare3_evt,
  input  wire logic          ext_irq1_evt,
  input  wire logic          change_notify_evt,
  input  wire logic          comparator_evt,
  input  wire logic          i2c1_master_evt,
  input  wire logic          i2c1_slave_evt,
  input  wire logic          parallel_port_evt,
  input  wire logic          compare5_evt,
  input  wire logic          capture5_evt,
  input  wire logic          capture4_evt,
  input  wire logic          capture3_evt,
  input  wire logic          spi2_event_evt,
  input  wire logic          spi2_fault_evt,
  input  wire logic          calendar_evt,
  input  wire logic          i2c2_master_evt,
  input  wire logic          i2c2_slave_evt,
  input  wire logic          charge_measure_evt,
  input  wire logic          low_voltage_evt,
  input  wire logic          crc_gen_evt,
  input  wire logic          uart2_error_evt,
  input  wire logic          uart1_error_evt,
  input  wire logic          usb_otg_evt,
  // forwarded requests
  output logic [15:0]        req_one,
  output logic [15:0]        req_two,
  output logic [15:0]        req_three,
  output logic [15:0]        req_four,
  output logic [15:0]        req_five,
  output logic               irq
);
  localparam int NB = `IFSB_NUM_BANKS;
  localparam logic [15:0] IMPL [NB] = '{
    `IFSB_IMPL_ONE, `IFSB_IMPL_TWO, `IFSB_IMPL_THREE,
    `IFSB_IMPL_FOUR, `IFSB_IMPL_FIVE};

  logic [15:0] set_v   [NB];
  logic [15:0] flag_v  [NB];
  logic [15:0] en_v    [NB];
  logic [NB-1:0] flag_we;
  logic [NB-1:0] en_we;
  logic [15:0] wr_data;
  logic [15:0] wr_mask;
  logic [16*NB-1:0] flags_flat;
  logic [16*NB-1:0] en_flat;
  logic [16*NB-1:0] req_flat;

  // event placement
  always_comb begin
    for (int i = 0; i < NB; i++) begin
      set_v[i] = 16'h0000;
    end
    set_v[0][`IFSB_B_UART2_TX]    = uart2_tx_evt;
    set_v[0][`IFSB_B_UART2_RX]    = uart2_rx_evt;
    set_v[0][`IFSB_B_EXT_IRQ2]    = ext_irq2_evt;
    set_v[0][`IFSB_B_TIMER5]      = timer5_evt;
    set_v[0][`IFSB_B_TIMER4]      = timer4_evt;
    set_v[0][`IFSB_B_COMPARE4]    = compare4_evt;
    set_v[0][`IFSB_B_COMPARE3]    = compare3_evt;
    set_v[0][`IFSB_B_EXT_IRQ1]    = ext_irq1_evt;
    set_v[0][`IFSB_B_CHANGE]      = change_notify_evt;
    set_v[0][`IFSB_B_COMPARATOR]  = comparator_evt;
    set_v[0][`IFSB_B_I2C1_MASTER] = i2c1_master_evt;
    set_v[0][`IFSB_B_I2C1_SLAVE]  = i2c1_slave_evt;
    set_v[1][`IFSB_B_PARALLEL]    = parallel_port_evt;
    set_v[1][`IFSB_B_COMPARE5]    = compare5_evt;
    set_v[1][`IFSB_B_CAPTURE5]    = capture5_evt;
    set_v[1][`IFSB_B_CAPTURE4]    = capture4_evt;
    set_v[1][`IFSB_B_CAPTURE3]    = capture3_evt;
    set_v[1][`IFSB_B_SPI2_EVENT]  = spi2_event_evt;
    set_v[1][`IFSB_B_SPI2_FAULT]  = spi2_fault_evt;
    set_v[2][`IFSB_B_CALENDAR]    = calendar_evt;
    set_v[2][`IFSB_B_I2C2_MASTER] = i2c2_master_evt;
    set_v[2][`IFSB_B_I2C2_SLAVE]  = i2c2_slave_evt;
    set_v[3][`IFSB_B_CHARGE]      = charge_measure_evt;
    set_v[3][`IFSB_B_LOW_VOLT]    = low_voltage_evt;
    set_v[3][`IFSB_B_CRC_GEN]     = crc_gen_evt;
    set_v[3][`IFSB_B_UART2_ERR]   = uart2_error_evt;
    set_v[3][`IFSB_B_UART1_ERR]   = uart1_error_evt;
    set_v[4][`IFSB_B_USB_OTG]     = usb_otg_evt;
  end

  // enables share the flag layout so unused bits stay zero
  for (genvar g = 0; g < NB; g++) begin : g_bank
    ifsb_flag_reg #(.IMPL(IMPL[g])) u_flag (
      .clk     (clk),
      .rst_b   (rst_b),
      .ce      (ce),
      .set     (set_v[g]),
      .wr_en   (flag_we[g]),
      .wr_data (wr_data),
      .wr_mask (wr_mask),
      .val_q   (flag_v[g])
    );
    ifsb_flag_reg #(.IMPL(IMPL[g])) u_en (
      .clk     (clk),
      .rst_b   (rst_b),
      .ce      (ce),
      .set     (16'h0000),
      .wr_en   (en_we[g]),
      .wr_data (wr_data),
      .wr_mask (wr_mask),
      .val_q   (en_v[g])
    );
    assign flags_flat[16*g +: 16] = flag_v[g];
    assign en_flat[16*g +: 16]    = en_v[g];
  end

  ifsb_req_stage #(.W(16*NB)) u_req (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .flags   (flags_flat),
    .enables (en_flat),
    .req_q   (req_flat),
    .irq_q   (irq)
  );

  assign req_one   = req_flat[15:0];
  assign req_two   = req_flat[31:16];
  assign req_three = req_flat[47:32];
  assign req_four  = req_flat[63:48];
  assign req_five  = req_flat[79:64];

  // write channel: address and data taken in either order
  ifsb_pkg::ifsb_wr_state_t wr_st_q, wr_st_d;
  logic          aw_held_q, aw_held_d;
  logic          w_held_q, w_held_d;
  logic [AW-1:0] awaddr_q, awaddr_d;
  logic [31:0]   wdata_q, wdata_d;
  logic [3:0]    wstrb_q, wstrb_d;
  logic          awready_d, wready_d, bvalid_d;
  logic [1:0]    bresp_d;
  logic          wr_hit;

  always_comb begin
    wr_st_d   = wr_st_q;
    aw_held_d = aw_held_q;
    w_held_d  = w_held_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = s_axi_bvalid;
    bresp_d   = s_axi_bresp;
    flag_we   = '0;
    en_we     = '0;
    wr_hit    = 1'b0;
    wr_data   = wdata_q[15:0];
    wr_mask   = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    case (wr_st_q)
      ifsb_pkg::IFSB_WR_IDLE: begin
        if (aw_held_q && w_held_q) begin
          for (int i = 0; i < NB; i++) begin
            if (awaddr_q == AW'(`IFSB_FLAG_BASE + 8'(i) * `IFSB_STRIDE)) begin
              flag_we[i] = 1'b1;
              wr_hit     = 1'b1;
            end
            if (awaddr_q == AW'(`IFSB_EN_BASE + 8'(i) * `IFSB_STRIDE)) begin
              en_we[i] = 1'b1;
              wr_hit   = 1'b1;
            end
          end
          aw_held_d = 1'b0;
          w_held_d  = 1'b0;
          bvalid_d  = 1'b1;
          bresp_d   = wr_hit ? `IFSB_RESP_OKAY : `IFSB_RESP_SLVERR;
          wr_st_d   = ifsb_pkg::IFSB_WR_RESP;
        end
      end
      ifsb_pkg::IFSB_WR_RESP: begin
        if (s_axi_bready) begin
          bvalid_d = 1'b0;
          wr_st_d  = ifsb_pkg::IFSB_WR_IDLE;
        end
      end
      default: begin
        wr_st_d  = ifsb_pkg::IFSB_WR_IDLE;
        bvalid_d = 1'b0;
      end
    endcase
    // no new beat while a response is owed
    awready_d = !aw_held_d && (wr_st_d == ifsb_pkg::IFSB_WR_IDLE);
    wready_d  = !w_held_d && (wr_st_d == ifsb_pkg::IFSB_WR_IDLE);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_st_q       <= ifsb_pkg::IFSB_WR_IDLE;
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `IFSB_RESP_OKAY;
    end else if (ce) begin
      wr_st_q       <= wr_st_d;
      aw_held_q     <= aw_held_d;
      w_held_q      <= w_held_d;
      awaddr_q      <= awaddr_d;
      wdata_q       <= wdata_d;
      wstrb_q       <= wstrb_d;
      s_axi_awready <= awready_d;
      s_axi_wready  <= wready_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
    end
  end

  // read channel
  ifsb_pkg::ifsb_rd_state_t rd_st_q, rd_st_d;
  logic        arready_d, rvalid_d;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_d;

  always_comb begin
    rd_st_d  = rd_st_q;
    rvalid_d = s_axi_rvalid;
    rdata_d  = s_axi_rdata;
    rresp_d  = s_axi_rresp;
    case (rd_st_q)
      ifsb_pkg::IFSB_RD_IDLE: begin
        if (s_axi_arvalid && s_axi_arready) begin
          rdata_d = 32'h0000_0000;
          rresp_d = `IFSB_RESP_SLVERR;
          for (int i = 0; i < NB; i++) begin
            if (s_axi_araddr ==
                AW'(`IFSB_FLAG_BASE + 8'(i) * `IFSB_STRIDE)) begin
              rdata_d = {16'h0000, flag_v[i]};
              rresp_d = `IFSB_RESP_OKAY;
            end
            if (s_axi_araddr ==
                AW'(`IFSB_EN_BASE + 8'(i) * `IFSB_STRIDE)) begin
              rdata_d = {16'h0000, en_v[i]};
              rresp_d = `IFSB_RESP_OKAY;
            end
          end
          rvalid_d = 1'b1;
          rd_st_d  = ifsb_pkg::IFSB_RD_RESP;
        end
      end
      ifsb_pkg::IFSB_RD_RESP: begin
        if (s_axi_rready) begin
          rvalid_d = 1'b0;
          rd_st_d  = ifsb_pkg::IFSB_RD_IDLE;
        end
      end
      default: begin
        rd_st_d  = ifsb_pkg::IFSB_RD_IDLE;
        rvalid_d = 1'b0;
      end
    endcase
    arready_d = (rd_st_d == ifsb_pkg::IFSB_RD_IDLE);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_st_q       <= ifsb_pkg::IFSB_RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `IFSB_RESP_OKAY;
    end else if (ce) begin
      rd_st_q       <= rd_st_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rdata   <= rdata_d;
      s_axi_rresp   <= rresp_d;
    end
  end
endmodule // ifsb_top
